// [dv/test_x25_frame_receiver.sv]
// Purpose: self-checking bench of the frame receiver
// Assumes: zero-wait APB slave, link model strobes a bit every 4 clocks
// Notes:   frame slot follows the expected sequence seq_exp, so a wrap reuses released slots
module test_x25_frame_receiver
  import xfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         rst;
  logic [11:0]  paddr;
  logic         psel, penable, pwrite, pready, pslverr, err, got;
  logic [31:0]  pwdata, prdata, rd;
  logic         rx_valid, rx_bit, resp_valid, resp_ready;
  xfr_resp_type resp_kind;
  logic [1:0]   kind;
  logic [2:0]   resp_nr, nr;
  logic [7:0]   held_frames;
  logic [7:0]   fq[$];
  int           n_fail = 0;
  int           tests_run = 0;
  int           cycles = 0;
  always #5 clk = ~clk;
  xfr_rx xfr_rx_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_bit(rx_bit), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp_kind(resp_kind), .resp_nr(resp_nr), .held_frames(held_frames));
  xfr_link_model #(.GAP(4)) xfr_link_model_inst (.clk(clk),
    .rx_valid(rx_valid), .rx_bit(rx_bit), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp_kind(resp_kind), .resp_nr(resp_nr));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // the longest frames dominate; ceiling leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [2:0] ns, input logic p, input logic m,
                       input int len, input logic bad);
    fq = {};
    for (int i = 0; i < len; i++)
      fq.push_back(i == 0 ? 8'hff : i == 1 ? {3'h0, p, ns, 1'b0} :
                   i == 4 ? {3'h0, m, 4'h0} : i == 10 ? 8'h00 :
                   {i[3:0], 4'hf});
    xfr_link_model_inst.send_frame(fq, bad);
  endtask
  task automatic resp(input int lag, input logic g, input logic [1:0] k,
                      input logic [2:0] n);
    xfr_link_model_inst.take_resp(lag, got, kind, nr);
    check({31'h0, got}, {31'h0, g});
    if (g) begin
      check({30'h0, kind}, {30'h0, k});
      check({29'h0, nr}, {29'h0, n});
    end
  endtask
  task automatic held(input logic [7:0] e);
    check({24'h0, held_frames}, {24'h0, e});
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, 32'h0);
    held(8'h00);
    apb(1'b1, REG_CTRL, 32'h1);
    $display("test reset finished");
    frame(3'd0, 1'b1, 1'b1, 12, 1'b0);
    resp(0, 1'b1, RESP_ACK, 3'd1);
    held(8'h01);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h20007, 32'h20001);
    apb(1'b1, REG_BUF_SEL, 32'h005);
    apb(1'b0, REG_BUF_DATA, 32'h0);
    check(rd & 32'h01ff00ff, 32'h000e005f);
    apb(1'b1, REG_HDR_SEL, 32'h0);
    apb(1'b0, REG_HDR_DATA, 32'h0);
    check(rd & 32'hffff, 32'h065f);
    $display("test good frame finished");
    frame(3'd1, 1'b0, 1'b1, 12, 1'b0);
    resp(0, 1'b0, 2'h0, 3'h0);
    frame(3'd5, 1'b1, 1'b1, 12, 1'b0);
    resp(0, 1'b1, RESP_REJECT, 3'd2);
    frame(3'd2, 1'b1, 1'b1, 12, 1'b1);
    resp(0, 1'b1, RESP_REJECT, 3'd2);
    held(8'h03);
    frame(3'd2, 1'b1, 1'b0, 12, 1'b0);
    resp(5, 1'b1, RESP_ACK, 3'd3);
    held(8'h07);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h20077, 32'h00023);
    $display("test reject and resend finished");
    frame(3'd3, 1'b1, 1'b0, 2, 1'b0);
    resp(0, 1'b1, RESP_REJECT, 3'd3);
    frame(3'd3, 1'b1, 1'b0, 254, 1'b0);
    resp(0, 1'b1, RESP_ACK, 3'd4);
    frame(3'd4, 1'b1, 1'b0, 255, 1'b0);
    resp(0, 1'b1, RESP_REJECT, 3'd4);
    $display("test lengths finished");
    xfr_link_model_inst.send_octet(FLAG_OCTET, 1'b0);
    xfr_link_model_inst.send_octet(8'h00, 1'b1);
    repeat (7) xfr_link_model_inst.send_bit(1'b1);
    xfr_link_model_inst.send_bit(1'b0);
    resp(0, 1'b1, RESP_ABORT, 3'd4);
    repeat (15) xfr_link_model_inst.send_bit(1'b1);
    resp(0, 1'b1, RESP_IDLE, 3'd4);
    apb(1'b0, REG_ERRS, 32'h0);
    check(rd & 32'hffffff, 32'h010103);
    apb(1'b1, REG_ERRS, 32'h0);
    apb(1'b0, REG_ERRS, 32'h0);
    check(rd, 32'h0);
    $display("test abort and idle finished");
    apb(1'b1, REG_CTRL, 32'h301);
    @(posedge clk);
    held(8'h0c);
    for (int s = 4; s < 8; s++)
      frame(s[2:0], 1'b0, 1'b1, 12, 1'b0);
    frame(3'd0, 1'b1, 1'b0, 12, 1'b0);
    resp(0, 1'b1, RESP_ACK, 3'd1);
    held(8'hfd);
    fq = {8'hff, 8'h11, 8'h00, 8'h00};
    xfr_link_model_inst.send_frame(fq, 1'b0);
    resp(0, 1'b0, 2'h0, 3'h0);
    held(8'hfd);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h7, 32'h1);
    apb(1'b0, 12'h0f0, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("test wrap and bus finished");
    end_sim();
  end
endmodule // test_x25_frame_receiver

// [dv/xfr_link_model.sv]
// Purpose: upstream transport_network node feeding line bits
// Assumes: one line bit every GAP clocks, low bit of each octet first
// Notes:   line bit shows the inverse of the last bit between strobes
module xfr_link_model
  import xfr_pkg::*;
#(
  parameter int GAP = 4
) (
  input  logic         clk,
  output logic         rx_valid,
  output logic         rx_bit,
  input  logic         resp_valid,
  output logic         resp_ready,
  input  xfr_resp_type resp_kind,
  input  logic [2:0]   resp_nr
);
  timeunit 1ns;
  timeprecision 1ps;
  int ones = 0;
  initial begin
    rx_valid = 1'b0;
    rx_bit = 1'b0;
    resp_ready = 1'b0;
  end
  task automatic send_bit(input logic b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_bit <= b;
    repeat (GAP - 1) begin
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_bit <= ~b;
    end
  endtask
  task automatic send_octet(input logic [7:0] v, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      send_bit(v[i]);
      ones = (stuff && v[i]) ? ones + 1 : 0;
      if (ones == 5) begin
        send_bit(1'b0);
        ones = 0;
      end
    end
  endtask
  // corrupt flips one check bit so the frame fails its check
  task automatic send_frame(input logic [7:0] fr[$], input logic corrupt);
    logic [15:0] crc;
    crc = CRC_INIT;
    ones = 0;
    send_octet(FLAG_OCTET, 1'b0);
    foreach (fr[k]) begin
      for (int i = 0; i < 8; i++)
        crc = (crc[0] ^ fr[k][i]) ? (crc >> 1) ^ CRC_POLY_REV : crc >> 1;
      send_octet(fr[k], 1'b1);
    end
    crc = ~crc ^ {15'h0, corrupt};
    send_octet(crc[7:0], 1'b1);
    send_octet(crc[15:8], 1'b1);
    send_octet(FLAG_OCTET, 1'b0);
  endtask
  // lag holds the response off to model a slow transmitter
  task automatic take_resp(input int lag, output logic got,
                           output logic [1:0] kind, output logic [2:0] nr);
    got = 1'b0;
    kind = 2'h0;
    nr = 3'h0;
    for (int i = 0; i < 100 && !got; i++) begin
      @(posedge clk);
      got = (resp_valid === 1'b1);
    end
    if (got) begin
      repeat (lag) @(posedge clk);
      kind = resp_kind;
      nr = resp_nr;
      resp_ready <= 1'b1;
      @(posedge clk);
      resp_ready <= 1'b0;
    end
  endtask
endmodule // xfr_link_model

// [rtl/xfr_crc16.sv]
// Purpose: bit-serial frame check over destuffed bits
// Assumes: low bit of each octet first, reflected polynomial
// Notes:   a good frame leaves the fixed residue after its check bits
module xfr_crc16
  import xfr_pkg::*;
(
  input  logic        clk,
  input  logic        rst,
  input  logic        clr,
  input  logic        bit_valid,
  input  logic        bit_in,
  output logic [15:0] crc
);
  always_ff @(posedge clk) begin
    if (rst || clr) begin
      crc <= CRC_INIT;
    end else if (bit_valid) begin // R23
      crc <= (crc >> 1) ^ ((crc[0] ^ bit_in) ? CRC_POLY_REV : 16'h0000);
    end
  end
endmodule // xfr_crc16

// [rtl/xfr_destuff.sv]
// Purpose: flag, abort and idle detection and zero removal
// Assumes: bit_valid strobes one line bit at the link rate
// Notes:   bits leave through an 8-bit window so a flag never leaks out
module xfr_destuff
  import xfr_pkg::*;
(
  input  logic clk,
  input  logic rst,
  input  logic bit_valid,
  input  logic bit_in,
  output logic dat_valid,
  output logic dat,
  output logic flag,
  output logic abort,
  output logic idle
);
  logic [7:0] win;
  logic [7:0] vld;
  logic [3:0] raw_ones;
  logic [2:0] out_ones;
  logic       flag_pend;
  logic [7:0] nwin;
  logic [7:0] nvld;

  assign nwin = {bit_in, win[7:1]};
  assign nvld = {1'b1, vld[7:1]};

  always_ff @(posedge clk) begin
    if (rst) begin
      win       <= 8'h00;
      vld       <= 8'h00;
      raw_ones  <= 4'h0;
      out_ones  <= 3'h0;
      dat_valid <= 1'b0;
      dat       <= 1'b0;
      flag      <= 1'b0;
      flag_pend <= 1'b0;
      abort     <= 1'b0;
      idle      <= 1'b0;
    end else begin
      dat_valid <= 1'b0;
      flag      <= flag_pend;
      flag_pend <= 1'b0;
      abort     <= 1'b0;
      idle      <= 1'b0;
      if (bit_valid) begin
        win <= nwin;
        if (!bit_in) begin
          raw_ones <= 4'h0;
        end else if (raw_ones != IDLE_RUN) begin
          raw_ones <= raw_ones + 4'h1;
        end
        idle <= bit_in && raw_ones == IDLE_RUN - 4'h1;
        // the oldest bit leaves even as a flag completes, else the last
        // check bit of every frame would be lost
        if (vld[0]) begin
          if (out_ones == STUFF_RUN && !win[0]) begin // R3
            out_ones <= 3'h0;
          end else begin
            dat_valid <= 1'b1;
            dat       <= win[0];
            out_ones  <= win[0] ? out_ones + 3'h1 : 3'h0;
          end
        end
        // flag trails that last bit by a cycle so the frame closes on it
        if (nwin == FLAG_OCTET && &nvld) begin // R1
          flag_pend <= 1'b1;
          vld       <= 8'h00;
          out_ones  <= 3'h0;
        end else if (bit_in && raw_ones == ABORT_RUN - 4'h1) begin
          abort    <= 1'b1;
          vld      <= 8'h00;
          out_ones <= 3'h0;
        end else begin
          vld <= nvld;
        end
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_stuff_drop;
    bit_valid && vld[0] && !win[0] && out_ones == STUFF_RUN
    |=> !dat_valid;
  endproperty
  a_stuff_drop: assert property (p_stuff_drop) // R3
    else $error("stuffed zero passed through");
endmodule // xfr_destuff

// [rtl/xfr_rx.sv]
// Purpose: receive side of the staging_interface frame link
// Assumes: rx_valid marks one line bit (56 kbit/s link)
// Notes:   responses leave as commands to a separate transmitter
// Function
// R1: every frame opens and closes with flag octet 01111110
// R2: sender inserts a zero after five ones inside a frame
// R3: receiver deletes the zero following five ones before decoding
// R4: first octet after the flag is the routing address, unchecked
// R5: second octet is control; its first bit 0 info, 1 supervisory
// R6: layer-3 multiple bit tells whether the packet continues
// R7: each frame's send sequence must equal the expected value
// R8: multiple bit checked so no frame of a packet goes missing
// R9: 16-bit frame check compared against carried value every frame
// R10: responses are reject, abort, idle, acknowledge; reject/ack carry count
// R11: ack only when check, sequence and poll all good; else silence
// R12: failed check or sequence sends a reject at once
// R13: on an error the frame is dropped and a response returned
// R14: frames run from 48 to 2048 bits, all lengths handled
// R15: instrument_packet spans 256 to 8,388,577 bits over several frames
// R16: successive frames rotate through eight frame buffers
// R17: primary and secondary headers copied to a header buffer
// R18: eight frames of a multi-frame packet held before forwarding
// R19: frames kept until count repeats so resends replace, never duplicate
// R20: after reject the sender resends all frames after the last ack
// R21: sender polls first, last and every fourth frame of a packet
// R22: link runs at 56 kbit/s; protocol logic kept modular
// R23: check covers address, control and data after zero removal
module xfr_rx
  import xfr_pkg::*;
#(
  parameter int FRAME_BYTES = MAX_FRAME_BYTES,
  parameter int HDR_BYTES   = HDR_BUF_BYTES
) (
  input  logic         clk,
  input  logic         rst,
  input  logic [11:0]  paddr,
  input  logic         psel,
  input  logic         penable,
  input  logic         pwrite,
  input  logic [31:0]  pwdata,
  output logic [31:0]  prdata,
  output logic         pready,
  output logic         pslverr,
  input  logic         rx_valid,
  input  logic         rx_bit,
  output logic         resp_valid,
  input  logic         resp_ready,
  output xfr_resp_type resp_kind,
  output logic [2:0]   resp_nr,
  output logic [7:0]   held_frames
);
  localparam int BW = $clog2(FRAME_BYTES);
  localparam int HW = $clog2(HDR_BYTES);

  generate
    if (FRAME_BYTES > MAX_FRAME_BYTES || FRAME_BYTES < MIN_FRAME_BYTES ||
        (1 << BW) != FRAME_BYTES || HDR_BYTES > 255 ||
        (1 << HW) != HDR_BYTES || HDR_BYTES < PRI_HDR_BYTES) begin : g_chk
      $error("xfr_rx: unsupported buffer sizes");
    end
  endgenerate

  typedef struct packed {
    xfr_rx_state_type st;
    logic             en;
    logic [7:0]       sr;
    logic [2:0]       bitcnt;
    logic [8:0]       bytecnt;
    logic [7:0]       ctl;
    logic             mbit;
    logic [2:0]       seq_exp;
    logic [2:0]       acked;
    logic [7:0]       hold;
    logic             pkt_open;
    logic             newpkt;
    logic [7:0]       hdr_len;
    logic             resp_valid;
    xfr_resp_type     resp_kind;
    logic [2:0]       resp_nr;
    logic [7:0]       n_fcs;
    logic [7:0]       n_seq;
    logic [7:0]       n_abort;
    logic [2:0]       bsel;
    logic [7:0]       bidx;
    logic [7:0]       hidx;
    logic [31:0]      prdata;
  } xfr_state_type;

  xfr_state_type s;
  xfr_state_type next_s;

  logic [7:0] fbuf [NUM_BUFS * FRAME_BYTES];
  logic [8:0] flen [NUM_BUFS];
  logic [7:0] hbuf [HDR_BYTES];

  logic        ds_v;
  logic        ds_d;
  logic        ds_flag;
  logic        ds_abort;
  logic        ds_idle;
  logic [15:0] crc;
  logic        in_fr;
  logic        byte_done;
  logic [7:0]  byte_v;
  logic        fr_end;
  logic        crc_ok;
  logic        short_fr;
  logic        is_s;
  logic        pf;
  logic [2:0]  ns;
  logic        seq_ok;
  logic        l3_ok;
  logic        acc;
  logic [7:0]  pos;
  logic        fb_we;
  logic        hb_we;
  logic        apb_wr;
  logic        hit;
  logic [31:0] rd;
  logic [8:0]  sec_total;

  xfr_destuff u_destuff ( // R22
    .clk       (clk),
    .rst       (rst),
    .bit_valid (rx_valid && s.en),
    .bit_in    (rx_bit),
    .dat_valid (ds_v),
    .dat       (ds_d),
    .flag      (ds_flag),
    .abort     (ds_abort),
    .idle      (ds_idle)
  );

  // the check restarts on every flag, so it spans only address onward
  xfr_crc16 u_crc (
    .clk       (clk),
    .rst       (rst),
    .clr       (ds_flag),
    .bit_valid (ds_v && in_fr),
    .bit_in    (ds_d),
    .crc       (crc)
  );

  assign in_fr     = s.st == RX_FRAME;
  assign byte_done = ds_v && in_fr && s.bitcnt == 3'h7;
  assign byte_v    = {ds_d, s.sr[7:1]};
  assign fr_end    = ds_flag && in_fr && (s.bytecnt != 9'h0 ||
                     s.bitcnt != 3'h0);
  assign crc_ok    = crc == CRC_GOOD; // R9
  assign short_fr  = s.bytecnt < 9'(MIN_FRAME_BYTES) || // R14
                     s.bytecnt > 9'(FRAME_BYTES) || s.bitcnt != 3'h0;
  // R4: the address octet is stored but never compared
  assign is_s      = s.ctl[CTL_S_BIT]; // R5
  assign pf        = s.ctl[CTL_PF_BIT];
  assign ns        = s.ctl[NS_LSB +: 3];
  assign seq_ok    = ns == s.seq_exp; // R7
  assign l3_ok     = s.bytecnt >= 9'(L3_MIN_BYTES); // R8
  assign acc       = fr_end && !short_fr && crc_ok && !is_s && seq_ok &&
                     l3_ok;
  assign pos       = 8'(s.bytecnt - 9'(INFO_IDX));
  assign fb_we     = byte_done && s.bytecnt < 9'(FRAME_BYTES);
  assign hb_we     = byte_done && s.newpkt && !is_s && // R17
                     s.bytecnt >= 9'(INFO_IDX) && pos < s.hdr_len;
  assign sec_total = 9'(PRI_HDR_BYTES) + {1'b0, byte_v};

  // frames land in the slot of the expected sequence number seq_exp, so a resend
  // overwrites its earlier copy instead of adding a second one
  always_ff @(posedge clk) begin
    if (fb_we) begin
      fbuf[{s.seq_exp, s.bytecnt[BW-1:0]}] <= byte_v; // R16 R19
    end
    if (acc) begin
      flen[ns] <= s.bytecnt;
    end
    if (hb_we) begin
      hbuf[pos[HW-1:0]] <= byte_v; // R17
    end
  end

  assign hit = paddr == REG_CTRL || paddr == REG_STATUS ||
               paddr == REG_ERRS || paddr == REG_BUF_SEL ||
               paddr == REG_BUF_DATA || paddr == REG_HDR_SEL ||
               paddr == REG_HDR_DATA;
  assign apb_wr  = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = s.prdata;

  always_comb begin
    rd = 32'h0;
    case (paddr)
      REG_CTRL:     rd = {31'h0, s.en};
      REG_STATUS:   rd = {13'h0, s.resp_valid, s.pkt_open, s.st,
                          s.hold, 1'b0, s.acked, 1'b0, s.seq_exp};
      REG_ERRS:     rd = {8'h0, s.n_abort, s.n_seq, s.n_fcs};
      REG_BUF_SEL:  rd = {21'h0, s.bsel, s.bidx};
      REG_BUF_DATA: rd = {7'h0, flen[s.bsel], 8'h0,
                          fbuf[{s.bsel, s.bidx[BW-1:0]}]};
      REG_HDR_SEL:  rd = {24'h0, s.hidx};
      REG_HDR_DATA: rd = {16'h0, s.hdr_len, hbuf[s.hidx[HW-1:0]]};
      default:      rd = 32'h0;
    endcase
  end

  always_comb begin
    next_s = s;
    if (psel && !penable) begin
      next_s.prdata = rd;
    end
    if (apb_wr) begin
      case (paddr)
        REG_CTRL: begin
          next_s.en   = pwdata[CTRL_EN_BIT];
          // R18: software forwards held frames, then frees their slots
          next_s.hold = s.hold & ~pwdata[CTRL_REL_LSB +: 8];
        end
        REG_ERRS: begin
          next_s.n_fcs   = 8'h0;
          next_s.n_seq   = 8'h0;
          next_s.n_abort = 8'h0;
        end
        REG_BUF_SEL: begin
          next_s.bsel = pwdata[10:8];
          next_s.bidx = pwdata[7:0];
        end
        REG_HDR_SEL: next_s.hidx = pwdata[7:0];
        default: next_s.hidx = s.hidx;
      endcase
    end
    if (s.resp_valid && resp_ready) begin
      next_s.resp_valid = 1'b0;
    end
    if (ds_v && in_fr) begin
      next_s.sr     = byte_v;
      next_s.bitcnt = s.bitcnt + 3'h1;
    end
    if (byte_done) begin
      if (s.bytecnt != 9'h1ff) begin
        next_s.bytecnt = s.bytecnt + 9'h1;
      end
      if (s.bytecnt == 9'(CTL_IDX)) begin
        next_s.ctl = byte_v; // R5
      end
      if (s.bytecnt == 9'(L3_M_IDX)) begin
        next_s.mbit = byte_v[M_BIT]; // R6
      end
      if (hb_we && pos == 8'(SEC_LEN_POS)) begin
        next_s.hdr_len = sec_total > 9'(HDR_BYTES) ? 8'(HDR_BYTES) :
                         sec_total[7:0];
      end
    end
    if (fr_end) begin
      if (short_fr || !crc_ok) begin // R12 R13
        next_s.resp_valid = 1'b1;
        next_s.resp_kind  = RESP_REJECT;
        next_s.resp_nr    = s.seq_exp; // R10
        next_s.n_fcs      = s.n_fcs + 8'h1;
      end else if (!is_s && !(seq_ok && l3_ok)) begin // R7 R8 R12
        next_s.resp_valid = 1'b1;
        next_s.resp_kind  = RESP_REJECT;
        next_s.resp_nr    = s.seq_exp;
        next_s.n_seq      = s.n_seq + 8'h1;
      end else if (acc) begin
        next_s.seq_exp  = s.seq_exp + 3'h1;
        next_s.hold[ns] = 1'b1; // R16 R18
        next_s.pkt_open = s.mbit; // R6 R15
        if (pf) begin // R11
          next_s.resp_valid = 1'b1;
          next_s.resp_kind  = RESP_ACK;
          next_s.resp_nr    = s.seq_exp + 3'h1; // R10
          next_s.acked      = ns;
        end
      end
    end
    if (ds_flag) begin // R1
      next_s.st      = RX_FRAME;
      next_s.bytecnt = 9'h0;
      next_s.bitcnt  = 3'h0;
      next_s.newpkt  = !next_s.pkt_open;
      next_s.hdr_len = 8'(PRI_HDR_BYTES);
    end
    if (ds_abort && in_fr) begin // R13
      next_s.st         = RX_HUNT;
      next_s.resp_valid = 1'b1;
      next_s.resp_kind  = RESP_ABORT;
      next_s.resp_nr    = s.seq_exp;
      next_s.n_abort    = s.n_abort + 8'h1;
    end
    if (ds_idle) begin // R10
      next_s.st         = RX_HUNT;
      next_s.resp_valid = 1'b1;
      next_s.resp_kind  = RESP_IDLE;
      next_s.resp_nr    = s.seq_exp;
    end
    if (!s.en) begin
      next_s.st = RX_HUNT;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s           <= '0;
      s.st        <= RX_HUNT;
      s.en        <= CTRL_EN_RESET;
      s.hdr_len   <= 8'(PRI_HDR_BYTES);
      s.newpkt    <= 1'b1;
      s.resp_kind <= RESP_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign resp_valid  = s.resp_valid;
  assign resp_kind   = s.resp_kind;
  assign resp_nr     = s.resp_nr;
  assign held_frames = s.hold;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_fcs_rej;
    fr_end && !crc_ok |=> s.resp_valid && s.resp_kind == RESP_REJECT &&
      s.resp_nr == $past(s.seq_exp);
  endproperty
  a_fcs_rej: assert property (p_fcs_rej) // R12
    else $error("bad check did not reject");

  property p_ack;
    acc && pf |=> s.resp_kind == RESP_ACK &&
      s.resp_nr == 3'($past(s.seq_exp) + 3'h1) && s.acked == $past(ns);
  endproperty
  a_ack: assert property (p_ack) // R11
    else $error("good polled frame not acknowledged");

  property p_silent;
    acc && !pf && !s.resp_valid |=> !s.resp_valid;
  endproperty
  a_silent: assert property (p_silent) // R11
    else $error("response sent without poll");

  property p_seq;
    fr_end && !short_fr && crc_ok && !is_s && !seq_ok
    |=> $stable(s.seq_exp) && s.resp_kind == RESP_REJECT;
  endproperty
  a_seq: assert property (p_seq) // R7
    else $error("out of order frame accepted");

  property p_rot;
    acc |=> s.hold[$past(ns)] && s.seq_exp == 3'($past(ns) + 3'h1);
  endproperty
  a_rot: assert property (p_rot) // R16
    else $error("accepted frame not held in its slot");

  property p_abort;
    ds_abort && in_fr && !ds_idle
    |=> s.st == RX_HUNT && s.resp_kind == RESP_ABORT ##1 s.st == RX_HUNT;
  endproperty
  a_abort: assert property (p_abort) // R13
    else $error("abort did not drop frame");

  property p_short;
    fr_end && short_fr |=> $stable(s.seq_exp) && s.resp_valid;
  endproperty
  a_short: assert property (p_short) // R14
    else $error("short frame accepted");

  property p_mbit;
    acc |=> s.pkt_open == $past(s.mbit) && s.newpkt == !$past(s.mbit);
  endproperty
  a_mbit: assert property (p_mbit) // R6
    else $error("multiple bit not tracked");
endmodule // xfr_rx

// [shared/xfr_pkg.sv]
// Purpose: constants and types of the frame receiver
// Assumes: bits arrive low bit of each octet first
// Notes:   one aligned 32-bit word per register
package xfr_pkg;
  localparam logic [7:0]  FLAG_OCTET      = 8'h7e;
  localparam logic [2:0]  STUFF_RUN       = 3'h5;
  localparam logic [3:0]  ABORT_RUN       = 4'h7;
  localparam logic [3:0]  IDLE_RUN        = 4'hf;
  localparam logic [15:0] CRC_INIT        = 16'hffff;
  localparam logic [15:0] CRC_POLY_REV    = 16'h8408;
  localparam logic [15:0] CRC_GOOD        = 16'hf0b8;
  localparam int          MIN_FRAME_BITS  = 48;
  localparam int          MAX_FRAME_BITS  = 2048;
  localparam int          MIN_FRAME_BYTES = MIN_FRAME_BITS / 8;
  localparam int          MAX_FRAME_BYTES = MAX_FRAME_BITS / 8;
  localparam int          NUM_BUFS        = 8;
  localparam int          CTL_IDX         = 1;
  localparam int          CTL_S_BIT       = 0;
  localparam int          NS_LSB          = 1;
  localparam int          CTL_PF_BIT      = 4;
  localparam int          L3_M_IDX        = 4;
  localparam int          M_BIT           = 4;
  localparam int          INFO_IDX        = 5;
  localparam int          L3_MIN_BYTES    = 7;
  localparam int          PRI_HDR_BYTES   = 6;
  localparam int          SEC_LEN_POS     = 5;
  localparam int          HDR_BUF_BYTES   = 64;
  localparam logic [11:0] REG_CTRL        = 12'h000;
  localparam logic [11:0] REG_STATUS      = 12'h004;
  localparam logic [11:0] REG_ERRS        = 12'h008;
  localparam logic [11:0] REG_BUF_SEL     = 12'h00c;
  localparam logic [11:0] REG_BUF_DATA    = 12'h010;
  localparam logic [11:0] REG_HDR_SEL     = 12'h014;
  localparam logic [11:0] REG_HDR_DATA    = 12'h018;
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_REL_LSB    = 8;
  localparam logic        CTRL_EN_RESET   = 1'b0;
  typedef enum logic [1:0] {
    RESP_REJECT, RESP_ABORT, RESP_IDLE, RESP_ACK
  } xfr_resp_type;
  typedef enum logic {RX_HUNT, RX_FRAME} xfr_rx_state_type;
endpackage
